// ==== core/sadc_ctrl.sv ====
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_regs.svh"
// Functional notes
// - Trigger 000: conversion starts when software clears the sample bit.
// - Trigger 111: conversion starts after auto_sample_time converter clocks.
// - Other trigger codes take timer or external event triggers.
// - Clearing converter_on aborts conversion, halts sequencing until next trigger.
// - Aborted conversion never writes result_buffer.
// - Off-clear beats a coinciding auto-start.
// - Conversion lasts fourteen converter clocks.
// - Converter clock is instruction cycle times half of divider plus one.
// - rc_clock_select picks the RC oscillator clock.
// - converter_on low disables digital and analog portions.
// - Sleep without rc_clock_select holds clocks low and aborts a running conversion.
// - Sleep without rc_clock_select leaves control and result registers unchanged.
// - RC clock works in sleep; one instruction cycle delay before converting.
// - RC conversion end clears converting_flag and writes result_buffer.
// - After sleep conversion wake if interrupt enabled, else power off.
// - Setting sample bit starts acquisition when configured and on.
// - Done and irq flag set after samples_per_interrupt plus one conversions.
// - Idle stops the module when idle_stop_select is one.
module sadc_ctrl (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                rc_clk_tick,
  input  wire logic                timer_trig,
  input  wire logic                ext_trig,
  input  wire logic                cpu_sleep,
  input  wire logic                cpu_idle,
  input  wire logic                sar_bit_ready,
  input  wire sadc_pkg::sadc_data_t sar_data,
  output logic                     sh_sample,
  output logic                     sar_convert,
  output logic                     analog_enable,
  output logic                     wake_request
);
  import sadc_pkg::*;

  logic [2:0] trig_sync;
  logic [2:0] trig_meta;
  logic [1:0] pwr_meta;
  logic [1:0] pwr_sync;
  logic       tick_prev;
  logic       converter_on, sample_control_bit, auto_sample_enable, done_flag;
  logic       converter_irq_flag, irq_enable, idle_stop_select, rc_clock_select;
  sadc_trig_t trigger_source_select;
  logic [4:0] auto_sample_time;
  logic [5:0] clock_divider_select;
  logic [3:0] samples_per_interrupt;
  sadc_data_t result_buffer;
  sadc_state_t state, next_state;
  logic [4:0] tad_cnt, next_tad_cnt;
  logic [3:0] converting_flag_cnt, next_converting_flag_cnt;
  logic [1:0] rc_dly, next_rc_dly;
  logic       powered_down, next_powered_down;
  logic       next_on, next_sample_control_bit, next_auto_sample_enable, next_done, next_irqf;
  logic       next_irqen, next_idle, next_rc;
  sadc_trig_t next_ssrc;
  logic [4:0] next_samc;
  logic [5:0] next_adcs;
  logic [3:0] next_smpi;
  sadc_data_t next_result;
  logic [31:0] next_prdata;
  logic       wr, rd, hit, tick, div_tick, rc_edge, halted, trig_prev, next_trig_prev;
  logic       hw_trig, converting_flag_done;

  // Pins pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_meta <= 3'b000;
      trig_sync <= 3'b000;
      pwr_meta  <= 2'b00;
      pwr_sync  <= 2'b00;
      tick_prev <= 1'b0;
    end else begin
      trig_meta <= {rc_clk_tick, ext_trig, timer_trig};
      trig_sync <= trig_meta;
      pwr_meta  <= {cpu_idle, cpu_sleep};
      pwr_sync  <= pwr_meta;
      tick_prev <= trig_sync[2];
    end
  end

  sadc_tad_gen u_tad (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (converter_on && !rc_clock_select && !halted),
    .divsel   (clock_divider_select),
    .tad_tick (div_tick)
  );

  assign rc_edge = trig_sync[2] && !tick_prev;
  // Sleep stops the divided clock; RC keeps running
  assign halted  = (pwr_sync[0] && !rc_clock_select) || (pwr_sync[1] && idle_stop_select);
  assign tick    = rc_clock_select ? (rc_edge && !(pwr_sync[1] && idle_stop_select))
                                   : div_tick;
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !penable && !pwrite;
  assign hit     = (paddr == `SADC_CTRL_OFF) || (paddr == `SADC_CFG_OFF) ||
                   (paddr == `SADC_STAT_OFF) || (paddr == `SADC_RESULT_OFF);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign next_trig_prev = trigger_source_select[0] ? trig_sync[1] : trig_sync[0];
  assign hw_trig = next_trig_prev && !trig_prev;
  assign converting_flag_done = (state == SADC_CONVERTING_FLAG) && tick && (converting_flag_cnt == 4'd13);

  always_comb begin
    next_on = converter_on;
    next_sample_control_bit = sample_control_bit;
    next_auto_sample_enable = auto_sample_enable;
    next_done = done_flag;
    next_irqf = converter_irq_flag;
    next_irqen = irq_enable;
    next_idle = idle_stop_select;
    next_ssrc = trigger_source_select;
    next_samc = auto_sample_time;
    next_adcs = clock_divider_select;
    next_rc = rc_clock_select;
    next_smpi = samples_per_interrupt;
    next_result = result_buffer;
    next_state = state;
    next_tad_cnt = tad_cnt;
    next_converting_flag_cnt = converting_flag_cnt;
    next_rc_dly = rc_dly;
    next_powered_down = powered_down;
    if (wr && paddr == `SADC_CTRL_OFF) begin
      next_on    = pwdata[`SADC_CTRL_ON];
      next_sample_control_bit  = pwdata[`SADC_CTRL_SAMPLE_CONTROL_BIT];
      next_auto_sample_enable  = pwdata[`SADC_CTRL_AUTO_SAMPLE_ENABLE];
      next_irqen = pwdata[`SADC_CTRL_IRQEN];
      next_idle  = pwdata[`SADC_CTRL_IDLE];
      // Write zero clears flags
      if (!pwdata[`SADC_CTRL_DONE]) next_done = 1'b0;
      if (!pwdata[`SADC_CTRL_IRQF]) next_irqf = 1'b0;
      if (pwdata[`SADC_CTRL_ON] && !converter_on) next_powered_down = 1'b0;
    end
    if (wr && paddr == `SADC_CFG_OFF) begin
      next_ssrc = pwdata[`SADC_CFG_SSRC_LSB +: 3];
      next_samc = pwdata[`SADC_CFG_SAMC_LSB +: 5];
      next_adcs = pwdata[`SADC_CFG_ADCS_LSB +: 6];
      next_rc   = pwdata[`SADC_CFG_RC_BIT];
      next_smpi = pwdata[`SADC_CFG_SMPI_LSB +: 4];
    end
    case (state)
      SADC_OFF: begin
        next_tad_cnt = 5'd0;
        next_converting_flag_cnt = 4'd0;
        next_rc_dly = 2'd0;
        if (next_on && !powered_down) next_state = SADC_IDLE;
      end
      SADC_IDLE: begin
        if (next_sample_control_bit) begin
          next_state = SADC_SAMPLE_CONTROL_BIT;
          next_tad_cnt = 5'd0;
        end
      end
      SADC_SAMPLE_CONTROL_BIT: begin
        if (trigger_source_select == SADC_TRIG_SW && !next_sample_control_bit) begin
          next_state = SADC_CONVERTING_FLAG;
        end else if (trigger_source_select == SADC_TRIG_AUTO) begin
          if (tick) next_tad_cnt = tad_cnt + 5'd1;
          if (tick && tad_cnt + 5'd1 >= auto_sample_time) begin
            next_state = SADC_CONVERTING_FLAG;
            next_sample_control_bit = 1'b0;
          end
        end else if (trigger_source_select != SADC_TRIG_SW && hw_trig) begin
          next_state = SADC_CONVERTING_FLAG;
          next_sample_control_bit = 1'b0;
        end
        // Two pclk make one instruction cycle before an RC conversion
        if (next_state == SADC_CONVERTING_FLAG) begin
          next_converting_flag_cnt = 4'd0;
          next_rc_dly = rc_clock_select ? `SADC_RC_START_DLY : 2'd0;
        end
      end
      SADC_CONVERTING_FLAG: begin
        if (rc_dly != 2'd0) begin
          next_rc_dly = rc_dly - 2'd1;
        end else if (tick) begin
          next_converting_flag_cnt = converting_flag_cnt + 4'd1;
          if (converting_flag_done) begin
            next_result = sar_data;
            next_tad_cnt = 5'd0;
            next_state = auto_sample_enable ? SADC_SAMPLE_CONTROL_BIT : SADC_IDLE;
            if (auto_sample_enable) next_sample_control_bit = 1'b1;
            if (pwr_sync[0] && !irq_enable) next_powered_down = 1'b1;
          end
        end
      end
      default: next_state = SADC_OFF;
    endcase
    // Sleep without RC abandons the conversion, registers kept
    if (state == SADC_CONVERTING_FLAG && pwr_sync[0] && !rc_clock_select) next_state = SADC_IDLE;
    // Off wins over state, sample bit and result in the same cycle; result written only when a conversion ends into sleep power-down
    if (!next_on || next_powered_down) begin
      next_state = SADC_OFF;
      next_sample_control_bit = 1'b0;
      next_result = (converting_flag_done && next_on) ? next_result : result_buffer;
    end
  end

  // Sample-count per interrupt could reuse tad_cnt only outside sampling; keep separate
  logic [3:0] seq_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_cnt <= 4'h0;
    end else if (!converter_on) begin
      seq_cnt <= 4'h0;
    end else if (converting_flag_done) begin
      seq_cnt <= (seq_cnt == samples_per_interrupt) ? 4'h0 : seq_cnt + 4'h1;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        `SADC_CTRL_OFF: next_prdata = {25'h0, idle_stop_select, irq_enable, converter_irq_flag,
                                       done_flag, auto_sample_enable, sample_control_bit,
                                       converter_on};
        `SADC_CFG_OFF: next_prdata = {12'h000, samples_per_interrupt, 1'b0, rc_clock_select,
                                      clock_divider_select, auto_sample_time,
                                      trigger_source_select};
        `SADC_STAT_OFF: next_prdata = {28'h0, wake_request, analog_enable,
                                       state == SADC_SAMPLE_CONTROL_BIT, state == SADC_CONVERTING_FLAG};
        `SADC_RESULT_OFF: next_prdata = {20'h0, result_buffer};
        default: next_prdata = 32'h0000_0000;
      endcase
    end else if (psel && penable) begin
      next_prdata = prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on <= 1'b0;
      sample_control_bit <= 1'b0;
      auto_sample_enable <= 1'b0;
      done_flag <= 1'b0;
      converter_irq_flag <= 1'b0;
      irq_enable <= 1'b0;
      idle_stop_select <= 1'b0;
      trigger_source_select <= SADC_TRIG_SW;
      auto_sample_time <= 5'h01;
      clock_divider_select <= 6'h00;
      rc_clock_select <= 1'b0;
      samples_per_interrupt <= 4'h0;
      result_buffer <= 12'h000;
      state <= SADC_OFF;
      tad_cnt <= 5'h00;
      converting_flag_cnt <= 4'h0;
      rc_dly <= 2'h0;
      powered_down <= 1'b0;
      trig_prev <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      converter_on <= next_on;
      sample_control_bit <= next_sample_control_bit;
      auto_sample_enable <= next_auto_sample_enable;
      done_flag <= next_done || (converting_flag_done && seq_cnt == samples_per_interrupt);
      converter_irq_flag <= next_irqf || (converting_flag_done && seq_cnt == samples_per_interrupt);
      irq_enable <= next_irqen;
      idle_stop_select <= next_idle;
      trigger_source_select <= next_ssrc;
      auto_sample_time <= next_samc;
      clock_divider_select <= next_adcs;
      rc_clock_select <= next_rc;
      samples_per_interrupt <= next_smpi;
      result_buffer <= next_result;
      state <= next_state;
      tad_cnt <= next_tad_cnt;
      converting_flag_cnt <= next_converting_flag_cnt;
      rc_dly <= next_rc_dly;
      powered_down <= next_powered_down;
      trig_prev <= next_trig_prev;
      prdata <= next_prdata;
    end
  end

  // Analog side follows state; all low while off, sar_convert also low while clocks stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_sample <= 1'b0;
      sar_convert <= 1'b0;
      analog_enable <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      sh_sample <= (next_state == SADC_SAMPLE_CONTROL_BIT);
      sar_convert <= (next_state == SADC_CONVERTING_FLAG) && !halted;
      analog_enable <= converter_on && !powered_down;
      wake_request <= converting_flag_done && pwr_sync[0] && irq_enable;
    end
  end
endmodule : sadc_ctrl
`default_nettype wire

// ==== core/sadc_regs.svh ====
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH
// APB byte offsets
`define SADC_CTRL_OFF      12'h000
`define SADC_CFG_OFF       12'h004
`define SADC_STAT_OFF      12'h008
`define SADC_RESULT_OFF    12'h00C
// Control register fields
`define SADC_CTRL_ON       0
`define SADC_CTRL_SAMPLE_CONTROL_BIT     1
`define SADC_CTRL_AUTO_SAMPLE_ENABLE     2
`define SADC_CTRL_DONE     3
`define SADC_CTRL_IRQF     4
`define SADC_CTRL_IRQEN    5
`define SADC_CTRL_IDLE     6
// Config register fields
`define SADC_CFG_SSRC_LSB  0
`define SADC_CFG_SAMC_LSB  3
`define SADC_CFG_ADCS_LSB  8
`define SADC_CFG_RC_BIT    14
`define SADC_CFG_SMPI_LSB  16
// Status register fields
`define SADC_STAT_CONVERTING_FLAG     0
`define SADC_STAT_SAMPLING 1
`define SADC_STAT_POWERED  2
`define SADC_STAT_WAKE     3
// Timing
`define SADC_CONVERTING_FLAG_TADS     5'd14
`define SADC_RC_START_DLY  2'd2
`endif

// ==== core/sadc_pkg.sv ====
package sadc_pkg;
  typedef enum logic [3:0] {
    SADC_OFF  = 4'b0001,
    SADC_IDLE = 4'b0010,
    SADC_SAMPLE_CONTROL_BIT = 4'b0100,
    SADC_CONVERTING_FLAG = 4'b1000
  } sadc_state_t;
  typedef logic [2:0]  sadc_trig_t;
  typedef logic [11:0] sadc_data_t;
  localparam sadc_trig_t SADC_TRIG_SW   = 3'h0;
  localparam sadc_trig_t SADC_TRIG_AUTO = 3'h7;
endpackage : sadc_pkg

// ==== core/sadc_tad_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module sadc_tad_gen (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [5:0] divsel,
  output logic            tad_tick
);
  // Half instruction cycle per count: one pclk stands for INSTRUCTION_CYCLE_PERIOD/2
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  always_comb begin
    next_cnt = 6'h00;
    tad_tick = 1'b0;
    if (run) begin
      if (cnt >= divsel) begin
        tad_tick = 1'b1;
      end else begin
        next_cnt = cnt + 6'h01;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 6'h00;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule : sadc_tad_gen
`default_nettype wire

// ==== testbench/sadc_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module sadc_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_sleep,
  input wire logic        sh_sample,
  input wire logic        sar_convert,
  input wire logic        analog_enable,
  input wire logic        wake_request
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [10:0] converting_flag_len;
  logic [10:0] next_converting_flag_len;
  // Saturates so a stuck converter cannot wrap
  always_comb begin
    next_converting_flag_len = 11'h000;
    if (sar_convert) begin
      next_converting_flag_len = (converting_flag_len == 11'h7ff) ? converting_flag_len : converting_flag_len + 11'h001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converting_flag_len <= 11'h000;
    end else begin
      converting_flag_len <= next_converting_flag_len;
    end
  end
  sequence s_off_write;
    psel && !penable ##1 psel && penable && pwrite && paddr == 12'h000 && !pwdata[0];
  endsequence
  sequence s_converting_flag_end;
    $fell(sar_convert) && !cpu_sleep ##1 analog_enable;
  endsequence
  a_pready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > 12'h00c)) else $error("pslverr wrong for address");
  a_off_abort: assert property (
    s_off_write |=> ##1 !sar_convert && !sh_sample && !analog_enable)
    else $error("converter still busy after switch off");
  a_acq_converting_flag_excl: assert property (
    !(sh_sample && sar_convert)) else $error("sampling and converting together");
  a_converting_flag_length: assert property (
    s_converting_flag_end |-> $past(converting_flag_len) >= 11'h00e) else $error("conversion too short");
  a_start_after_acq: assert property (
    $rose(sar_convert) |-> $past(sh_sample) || $past(sh_sample, 2))
    else $error("conversion without acquisition");
  a_busy_needs_on: assert property (
    sh_sample || sar_convert |-> analog_enable) else $error("busy while powered off");
  a_wake_pulse: assert property (
    wake_request |=> !wake_request) else $error("wake request longer than a cycle");
endmodule : sadc_monitor
`default_nettype wire

// ==== testbench/sadc_sar_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sadc_sar_model (
  input  wire logic                 sar_convert,
  input  wire sadc_pkg::sadc_data_t value,
  output logic                      sar_bit_ready,
  output sadc_pkg::sadc_data_t      sar_data
);
  import sadc_pkg::*;
  // Outside a conversion the result lines show junk, not the last value
  assign sar_data = sar_convert ? value : ~value;
  assign sar_bit_ready = sar_convert;
endmodule : sadc_sar_model
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sadc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        timer_trig, ext_trig, cpu_sleep, sar_bit_ready, cpu_idle;
  logic        rc_tick = 1'b0;
  logic        sh_sample, sar_convert, analog_enable, wake_request;
  sadc_data_t  sar_data, sdat;
  int          mismatches, n_checks, len;
  sadc_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rc_clk_tick(rc_tick), .timer_trig, .ext_trig, .cpu_sleep,
    .cpu_idle, .sar_bit_ready, .sar_data, .sh_sample, .sar_convert,
    .analog_enable, .wake_request);
  sadc_sar_model sar (.sar_convert, .value(sdat), .sar_bit_ready, .sar_data);
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  // Free-running RC oscillator, one rising edge every two pclk
  always @(posedge pclk) rc_tick <= presetn && !rc_tick;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Waits for the chosen level, then counts cycles it stays high
  task automatic hi_len(input bit acq);
    int n;
    n = 0;
    while ((acq ? sh_sample : sar_convert) !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    len = 0;
    while ((acq ? sh_sample : sar_convert) === 1'b1 && len < 2000) begin
      @(posedge pclk);
      len++;
    end
  endtask : hi_len
  initial begin
    #(100 * 20000);
    mismatches++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, timer_trig, ext_trig, cpu_sleep} = 7'h00;
    cpu_idle = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sdat = 12'h000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk("ctrl", 32'h0000_0000, rd);
    apb(0, 12'h004, 0);
    chk("cfg", 32'h0000_0008, rd);
    apb(0, 12'h010, 0);
    chk("unmapped err", 1, err);
    $display("test registers done");
    // Divider 3 and 5 keep the converter clock at 400 ns or more
    for (int d = 3; d < 6; d += 2) begin
      sdat <= 12'ha50 + 12'(d);
      apb(1, 12'h000, 0);
      apb(1, 12'h004, 32'h0000_0008 | (d << 8));
      apb(1, 12'h000, 1);
      repeat (4) @(posedge pclk);
      apb(1, 12'h000, 3);
      repeat (40) @(posedge pclk);
      chk("acquiring", 1, sh_sample);
      chk("no early converting_flag", 0, sar_convert);
      apb(1, 12'h000, 1);
      hi_len(0);
      chk("converting_flag len", 1, len >= 13 * (d + 1) && len <= 15 * (d + 1));
      apb(0, 12'h00c, 0);
      chk("result", 12'ha50 + d, rd);
      apb(0, 12'h000, 0);
      chk("done", 1, rd[3]);
    end
    $display("test software trigger done");
    apb(1, 12'h000, 0);
    apb(1, 12'h004, 32'h0000_031f);
    sdat <= 12'h3c1;
    apb(1, 12'h000, 7);
    hi_len(1);
    chk("acq len", 1, len >= 9 && len <= 15);
    hi_len(0);
    chk("auto converting_flag len", 1, len >= 52 && len <= 60);
    repeat (2) @(posedge pclk);
    chk("reacquire", 1, sh_sample);
    apb(0, 12'h00c, 0);
    chk("auto result", 12'h3c1, rd);
    sdat <= 12'h5e2;
    for (int n = 0; n < 50 && sar_convert !== 1'b1; n++) @(posedge pclk);
    repeat (8) @(posedge pclk);
    apb(1, 12'h000, 0);
    repeat (2) @(posedge pclk);
    chk("aborted", 0, {sar_convert, sh_sample, analog_enable});
    repeat (60) @(posedge pclk);
    chk("halted", 0, {sar_convert, sh_sample});
    apb(0, 12'h00c, 0);
    chk("kept result", 12'h3c1, rd);
    repeat (8) @(posedge pclk);
    $display("test auto start and abort done");
    for (int k = 1; k < 3; k++) begin
      apb(1, 12'h000, 0);
      apb(1, 12'h004, 32'h0000_0308 | k);
      apb(1, 12'h000, 3);
      repeat (10) @(posedge pclk);
      chk("wait trigger", 0, sar_convert);
      ext_trig <= (k == 1);
      timer_trig <= (k == 2);
      repeat (6) @(posedge pclk);
      ext_trig <= 1'b0;
      timer_trig <= 1'b0;
      chk("event converting_flag", 1, sar_convert);
      hi_len(0);
    end
    $display("test event triggers done");
    apb(1, 12'h000, 0);
    apb(1, 12'h004, 32'h0000_0308);
    apb(1, 12'h000, 3);
    sdat <= 12'h777;
    apb(1, 12'h000, 1);
    repeat (4) @(posedge pclk);
    cpu_sleep <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("sleep abort", 0, sar_convert);
    cpu_sleep <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("no resume", 0, sar_convert);
    apb(0, 12'h004, 0);
    chk("cfg kept", 32'h0000_0308, rd);
    apb(0, 12'h000, 0);
    chk("on kept", 1, rd[0]);
    apb(0, 12'h00c, 0);
    chk("sleep result", 12'h5e2, rd);
    $display("test sleep done");
    apb(1, 12'h000, 0);
    apb(1, 12'h004, 32'h0000_4008);
    apb(1, 12'h000, 32'h0000_0023);
    sdat <= 12'h6b4;
    repeat (10) @(posedge pclk);
    apb(1, 12'h000, 32'h0000_0021);
    cpu_sleep <= 1'b1;
    for (len = 0; len < 100 && wake_request !== 1'b1; len++) @(posedge pclk);
    chk("rc wake", 1, wake_request);
    repeat (2) @(posedge pclk);
    cpu_sleep <= 1'b0;
    apb(0, 12'h00c, 0);
    chk("rc result", 12'h6b4, rd);
    apb(1, 12'h000, 0);
    apb(1, 12'h004, 32'h0000_031f);
    cpu_idle <= 1'b1;
    apb(1, 12'h000, 32'h0000_0043);
    repeat (40) @(posedge pclk);
    chk("idle hold", 2, {sh_sample, sar_convert});
    cpu_idle <= 1'b0;
    hi_len(0);
    chk("idle resume", 1, len >= 52 && len <= 60);
    $display("test rc clock and idle done");
    wrap_up();
  end
endmodule : testbench
bind sadc_ctrl sadc_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .cpu_sleep, .sh_sample, .sar_convert, .analog_enable, .wake_request);
`default_nettype wire
